// File: hdl/ebtad_cs_decode.v
// Chip-select region decoder
`timescale 1ns/1ps
`include "ebtad_regs.vh"

module ebtad_cs_decode (
  // Address and region settings
  input  wire [7:0]   region,
  input  wire [255:0] area_flat,
  // Result
  output reg          hit_any,
  output reg  [2:0]   hit_idx
);

  wire [`EBTAD_NCS-1:0] match;
  integer k;

  // ==========================================================
  // Masked compare per chip select
  genvar g;
  generate
    for (g = 0; g < `EBTAD_NCS; g = g + 1) begin : g_cmp
      wire [31:0] area = area_flat[g*32 +: 32];
      wire [7:0]  keep = ~{1'b0, area[`EBTAD_F_MASK]};
      assign match[g] = ((region & keep) == (area[`EBTAD_F_BASE] & keep));
    end
  endgenerate

  // ==========================================================
  // Lowest index wins; overlapping regions are a software fault
  always @* begin
    hit_any = 1'b0;
    hit_idx = 3'h0;
    for (k = `EBTAD_NCS - 1; k >= 0; k = k - 1) begin
      if (match[k]) begin
        hit_any = 1'b1;
        hit_idx = k[2:0];
      end
    end
  end

endmodule // ebtad_cs_decode

// File: hdl/ebtad_reg_file.v
// Register storage for timing, region and mode settings
`timescale 1ns/1ps
`include "ebtad_regs.vh"

module ebtad_reg_file (
  // Clock and reset
  input  wire         clk,
  input  wire         reset,
  // Write and read port
  input  wire         wr_en,
  input  wire [4:0]   wr_idx,
  input  wire [31:0]  wr_data,
  input  wire [4:0]   rd_idx,
  input  wire [31:0]  status,
  output reg  [31:0]  rd_data,
  // Settings to the engine
  output wire [255:0] tim_flat,
  output wire [255:0] area_flat,
  output wire [23:0]  mode_flat
);

  reg [31:0] tim  [0:`EBTAD_NCS-1];
  reg [31:0] area [0:`EBTAD_NCS-1];
  reg [`EBTAD_MODE_W-1:0] mode [0:`EBTAD_NCS-1];
  integer i;

  // Group of an index: 0 timing, 1 area, 2 mode, 3 status or unmapped
  function [1:0] grp;
    input [4:0] idx;
    begin
      if (idx < `EBTAD_IDX_AREA)
        grp = 2'h0;
      else if (idx < `EBTAD_IDX_MODE)
        grp = 2'h1;
      else if (idx < `EBTAD_IDX_STAT)
        grp = 2'h2;
      else
        grp = 2'h3;
    end
  endfunction

  // ==========================================================
  // Storage
  always @(posedge clk) begin
    if (reset) begin
      for (i = 0; i < `EBTAD_NCS; i = i + 1) begin
        tim[i]  <= `EBTAD_TIM_RST;
        area[i] <= {9'h000, `EBTAD_MASK_RST, 8'h00, `EBTAD_BASE_STEP * i[7:0]};
        mode[i] <= `EBTAD_MODE_RST;
      end
    end else if (wr_en) begin
      case (grp(wr_idx))
        2'h0: tim[wr_idx[2:0]] <= wr_data;
        2'h1: area[wr_idx[2:0]] <= wr_data & `EBTAD_AREA_WMASK;
        2'h2: mode[wr_idx[2:0]] <= wr_data[`EBTAD_MODE_W-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Read mux; unmapped words read as zero
  always @* begin
    case (grp(rd_idx))
      2'h0: rd_data = tim[rd_idx[2:0]];
      2'h1: rd_data = area[rd_idx[2:0]];
      2'h2: rd_data = {29'h0, mode[rd_idx[2:0]]};
      default: rd_data = (rd_idx == `EBTAD_IDX_STAT) ? status : 32'h0;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < `EBTAD_NCS; g = g + 1) begin : g_flat
      assign tim_flat[g*32 +: 32] = tim[g];
      assign area_flat[g*32 +: 32] = area[g];
      assign mode_flat[g*3 +: 3] = mode[g];
    end
  endgenerate

endmodule // ebtad_reg_file

// File: hdl/ebtad_regs.vh
// Constants for the external bus timing and area decode block
`ifndef EBTAD_REGS_VH
`define EBTAD_REGS_VH

// ==========================================================
// Bus and address map
`define EBTAD_NCS          8
`define EBTAD_WIN_BIT      28
`define EBTAD_REG_IDX      6:2
`define EBTAD_REG_LAST     5'h18
`define EBTAD_IDX_TIM      5'h00
`define EBTAD_IDX_AREA     5'h08
`define EBTAD_IDX_MODE     5'h10
`define EBTAD_IDX_STAT     5'h18
`define EBTAD_REGION       27:20
`define EBTAD_PAGE_TAG     27:4

// ==========================================================
// Access timing register fields
`define EBTAD_F_WIDLE      31:28
`define EBTAD_F_WSTRB      27:24
`define EBTAD_F_WSETUP     23:20
`define EBTAD_F_WRITE_ACCESS_CYCLES       19:16
`define EBTAD_F_RIDLE      15:12
`define EBTAD_F_FIRST      11:8
`define EBTAD_F_RSETUP     7:4
`define EBTAD_F_READ_ACCESS_CYCLES       3:0
`define EBTAD_TIM_RST      32'h055ff00f

// ==========================================================
// Region decode register fields
`define EBTAD_F_MASK       22:16
`define EBTAD_F_BASE       7:0
`define EBTAD_AREA_WMASK   32'h007f00ff
`define EBTAD_MASK_RST     7'h0f
`define EBTAD_BASE_STEP    8'h10

// ==========================================================
// Mode register bits
`define EBTAD_M_PAGE       0
`define EBTAD_M_SWS        1
`define EBTAD_M_NAND       2
`define EBTAD_MODE_W       3
`define EBTAD_MODE_RST     3'h0

// ==========================================================
// Bus protocol and state codes
`define EBTAD_HRESP_OKAY   1'b0
`define EBTAD_HRESP_ERROR  1'b1
`define EBTAD_ST_IDLE      3'h0
`define EBTAD_ST_ACC       3'h1
`define EBTAD_ST_GAP       3'h2
`define EBTAD_ST_ERR1      3'h3
`define EBTAD_ST_ERR2      3'h4
`define EBTAD_ST_REGRD     3'h5

`endif

// File: hdl/ebtad_top.v
// External memory bus timing engine with chip-select area decode
//
// Functional notes
// - Write setup lasts code plus one, strobe off
// - Write access lasts code plus one, address held
// - Idle of code plus one after reads
// - First-read field unused when page off, select zero
// - Select one, page off: read strobe lasts first-read plus one
// - Page on, select zero: first access waits first-read cycles
// - Reduced variant ignores first-read strobe width
// - Read setup lasts exactly code cycles, strobe off
// - Read access lasts code plus one, data sampled last
// - NAND strobes follow ordinary strobe timing
// - Masked compare of address 27:20 with base
// - Mask sets region size, reset gives 16MB
// - Base maps onto address 27:20 of window
// - Only 25 external address bits driven
// - Unmapped window access gets error response
// - Page reads continue to 16-byte boundary
// - Select zero: strobe is access minus setup
// - Timing changes apply only after access completes
`timescale 1ns/1ps
`include "ebtad_regs.vh"

module ebtad_top #(
  parameter REDUCED = 0,
  parameter AW      = 25,
  parameter DW      = 32
) (
  // Clock and reset
  input  wire          SYS_CLK,
  input  wire          RESET,
  // AHB-Lite slave
  input  wire          HSEL,
  input  wire [31:0]   HADDR,
  input  wire [1:0]    HTRANS,
  input  wire          HWRITE,
  input  wire [2:0]    HSIZE,
  input  wire [31:0]   HWDATA,
  input  wire          HREADY,
  output reg           HREADYOUT,
  output reg           HRESP,
  output reg  [31:0]   HRDATA,
  // External memory
  output reg  [AW-1:0] MEM_ADDR,
  output reg  [7:0]    MEM_CHIP_SELECT_N,
  output reg           MEM_READ_STROBE_N,
  output reg           MEM_WRITE_STROBE_N,
  output reg           MEM_NAND_WRITE_STROBE_N,
  output reg           MEM_NAND_READ_STROBE_N,
  input  wire [DW-1:0] MEM_DQ_IN,
  output reg  [DW-1:0] MEM_DQ_OUT,
  output reg           MEM_DQ_OE_N
);

  // ==========================================================
  // Declarations
  reg  [2:0]   state;
  reg  [5:0]   cnt;
  reg  [5:0]   len;
  reg  [31:0]  t;
  reg  [2:0]   m;
  reg          a_wr;
  reg  [2:0]   a_cs;
  reg          page_vld;
  reg  [23:0]  page_tag;
  reg  [2:0]   page_cs;
  reg          wr_pend;
  reg  [4:0]   wr_idx;
  reg  [4:0]   rd_idx;
  reg  [2:0]   last_cs;
  reg          last_wr;
  reg          last_err;

  reg  [2:0]   next_state;
  reg  [5:0]   next_cnt;
  reg  [5:0]   next_len;
  reg  [31:0]  next_t;
  reg  [2:0]   next_m;
  reg          next_wr;
  reg  [2:0]   next_cs;
  reg          start;
  reg          next_rd_on;
  reg          next_wr_on;

  wire         hit_any;
  wire [2:0]   hit_idx;
  wire [255:0] tim_flat;
  wire [255:0] area_flat;
  wire [23:0]  mode_flat;
  wire [31:0]  reg_rdata;
  wire [31:0]  status = {26'h0, last_err, last_wr, 1'b0, last_cs};

  wire         ready_st = (state == `EBTAD_ST_IDLE) || (state == `EBTAD_ST_ERR2);
  wire         accept   = HSEL && HREADY && HTRANS[1] && ready_st;
  wire         is_reg   = HADDR[`EBTAD_WIN_BIT];
  wire [31:0]  tim_sel  = tim_flat[hit_idx*32 +: 32];
  wire [2:0]   mode_sel = mode_flat[hit_idx*3 +: 3];
  wire         page_hit = page_vld && (page_cs == hit_idx) && (page_tag == HADDR[`EBTAD_PAGE_TAG]);

  // ==========================================================
  // Leaves
  ebtad_cs_decode u_dec (
    .region    (HADDR[`EBTAD_REGION]),
    .area_flat (area_flat),
    .hit_any   (hit_any),
    .hit_idx   (hit_idx)
  );

  ebtad_reg_file u_regs (
    .clk       (SYS_CLK),
    .reset     (RESET),
    .wr_en     (wr_pend),
    .wr_idx    (wr_idx),
    .wr_data   (HWDATA),
    .rd_idx    (rd_idx),
    .status    (status),
    .rd_data   (reg_rdata),
    .tim_flat  (tim_flat),
    .area_flat (area_flat),
    .mode_flat (mode_flat)
  );

  // ==========================================================
  // Access sequencer
  always @* begin
    next_state = state;
    next_cnt   = cnt;
    next_len   = len;
    next_t     = t;
    next_m     = m;
    next_wr    = a_wr;
    next_cs    = a_cs;
    start      = 1'b0;
    case (state)
      `EBTAD_ST_IDLE, `EBTAD_ST_ERR2: begin
        next_state = `EBTAD_ST_IDLE;
        if (accept && is_reg && !HWRITE) begin
          next_state = `EBTAD_ST_REGRD;
        end else if (accept && !is_reg) begin
          if (hit_any) begin
            start      = 1'b1;
            next_state = `EBTAD_ST_ACC;
            next_cnt   = 6'h00;
            next_t     = tim_sel;
            next_m     = mode_sel;
            next_wr    = HWRITE;
            next_cs    = hit_idx;
            if (HWRITE)
              next_len = {2'b00, tim_sel[`EBTAD_F_WRITE_ACCESS_CYCLES]};
            else if (mode_sel[`EBTAD_M_PAGE] && !mode_sel[`EBTAD_M_SWS] && !page_hit)
              next_len = {2'b00, tim_sel[`EBTAD_F_FIRST]} + {2'b00, tim_sel[`EBTAD_F_READ_ACCESS_CYCLES]};
            else
              next_len = {2'b00, tim_sel[`EBTAD_F_READ_ACCESS_CYCLES]};
          end else begin
            next_state = `EBTAD_ST_ERR1;
          end
        end
      end
      `EBTAD_ST_ACC: begin
        if (cnt == len) begin
          next_state = `EBTAD_ST_GAP;
          next_cnt   = 6'h00;
          next_len   = a_wr ? {2'b00, t[`EBTAD_F_WIDLE]} : {2'b00, t[`EBTAD_F_RIDLE]};
        end else begin
          next_cnt = cnt + 6'h01;
        end
      end
      `EBTAD_ST_GAP: begin
        if (cnt == len)
          next_state = `EBTAD_ST_IDLE;
        else
          next_cnt = cnt + 6'h01;
      end
      `EBTAD_ST_ERR1: next_state = `EBTAD_ST_ERR2;
      `EBTAD_ST_REGRD: next_state = `EBTAD_ST_IDLE;
      default: next_state = `EBTAD_ST_IDLE;
    endcase
  end

  // ==========================================================
  // Strobe windows for the coming cycle
  always @* begin
    next_wr_on = (next_state == `EBTAD_ST_ACC) && next_wr &&
                 (next_cnt > {2'b00, next_t[`EBTAD_F_WSETUP]}) &&
                 (next_cnt <= {2'b00, next_t[`EBTAD_F_WSETUP]} + {2'b00, next_t[`EBTAD_F_WSTRB]} + 6'h01);
    next_rd_on = (next_state == `EBTAD_ST_ACC) && !next_wr &&
                 (next_cnt >= {2'b00, next_t[`EBTAD_F_RSETUP]});
    // Reduced parts lack the width option, so the select bit is ignored there
    if (REDUCED == 0 && next_m[`EBTAD_M_SWS] && !next_m[`EBTAD_M_PAGE]) begin
      if (next_cnt > {2'b00, next_t[`EBTAD_F_RSETUP]} + {2'b00, next_t[`EBTAD_F_FIRST]})
        next_rd_on = 1'b0;
    end
  end

  // ==========================================================
  // Registers
  always @(posedge SYS_CLK) begin
    if (RESET) begin
      state                   <= `EBTAD_ST_IDLE;
      cnt                     <= 6'h00;
      len                     <= 6'h00;
      t                       <= `EBTAD_TIM_RST;
      m                       <= `EBTAD_MODE_RST;
      a_wr                    <= 1'b0;
      a_cs                    <= 3'h0;
      page_vld                <= 1'b0;
      page_tag                <= 24'h000000;
      page_cs                 <= 3'h0;
      wr_pend                 <= 1'b0;
      wr_idx                  <= 5'h00;
      rd_idx                  <= 5'h00;
      last_cs                 <= 3'h0;
      last_wr                 <= 1'b0;
      last_err                <= 1'b0;
      HREADYOUT               <= 1'b1;
      HRESP                   <= `EBTAD_HRESP_OKAY;
      HRDATA                  <= 32'h00000000;
      MEM_ADDR                <= {AW{1'b0}};
      MEM_CHIP_SELECT_N       <= 8'hff;
      MEM_READ_STROBE_N       <= 1'b1;
      MEM_WRITE_STROBE_N      <= 1'b1;
      MEM_NAND_WRITE_STROBE_N <= 1'b1;
      MEM_NAND_READ_STROBE_N  <= 1'b1;
      MEM_DQ_OUT              <= {DW{1'b0}};
      MEM_DQ_OE_N             <= 1'b1;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      len       <= next_len;
      t         <= next_t;
      m         <= next_m;
      a_wr      <= next_wr;
      a_cs      <= next_cs;
      // Register writes land one cycle later, in the data phase
      wr_pend   <= accept && is_reg && HWRITE && (HADDR[`EBTAD_REG_IDX] < `EBTAD_REG_LAST);
      wr_idx    <= HADDR[`EBTAD_REG_IDX];
      if (accept && is_reg && !HWRITE)
        rd_idx <= HADDR[`EBTAD_REG_IDX];
      HREADYOUT <= (next_state == `EBTAD_ST_IDLE) || (next_state == `EBTAD_ST_ERR2);
      HRESP     <= ((next_state == `EBTAD_ST_ERR1) || (next_state == `EBTAD_ST_ERR2)) ?
                   `EBTAD_HRESP_ERROR : `EBTAD_HRESP_OKAY;
      if (state == `EBTAD_ST_REGRD)
        HRDATA <= reg_rdata;
      else if (state == `EBTAD_ST_ACC && !a_wr && cnt == len)
        HRDATA <= MEM_DQ_IN;
      if (next_state == `EBTAD_ST_ERR1)
        last_err <= 1'b1;
      else if (start)
        last_err <= 1'b0;
      if (start) begin
        MEM_ADDR <= HADDR[AW-1:0];
        last_cs  <= hit_idx;
        last_wr  <= HWRITE;
        page_tag <= HADDR[`EBTAD_PAGE_TAG];
        page_cs  <= hit_idx;
      end
      // A page stays open only across reads in page mode
      if (start && (HWRITE || !mode_sel[`EBTAD_M_PAGE]))
        page_vld <= 1'b0;
      else if (state == `EBTAD_ST_ACC && !a_wr && cnt == len && m[`EBTAD_M_PAGE])
        page_vld <= 1'b1;
      MEM_CHIP_SELECT_N <= (next_state == `EBTAD_ST_ACC) ? ~(8'h01 << next_cs) : 8'hff;
      // NAND mode moves the same windows onto the dedicated strobes
      MEM_READ_STROBE_N       <= ~(next_rd_on && !next_m[`EBTAD_M_NAND]);
      MEM_WRITE_STROBE_N      <= ~(next_wr_on && !next_m[`EBTAD_M_NAND]);
      MEM_NAND_READ_STROBE_N  <= ~(next_rd_on && next_m[`EBTAD_M_NAND]);
      MEM_NAND_WRITE_STROBE_N <= ~(next_wr_on && next_m[`EBTAD_M_NAND]);
      // Write data is in its data phase from access cycle 0 onward
      if (state == `EBTAD_ST_ACC && a_wr)
        MEM_DQ_OUT <= HWDATA;
      MEM_DQ_OE_N <= ~(state == `EBTAD_ST_ACC && a_wr && next_state == `EBTAD_ST_ACC);
    end
  end

endmodule // ebtad_top

// File: sim/ebtad_mem_model.sv
// Behavioural external memory behind the chip selects
`timescale 1ns/1ps
// ==========================================================
// Memory model
module ebtad_mem_model (
  // Memory pins
  input  wire        clk,
  input  wire [24:0] addr,
  input  wire [7:0]  cs_n,
  input  wire        rd_n,
  input  wire        wr_n,
  input  wire        nrd_n,
  input  wire        nwr_n,
  // Data
  input  wire [31:0] dq_out,
  input  wire        oe_n,
  output wire [31:0] dq_in
);
  reg  [31:0] mem [0:15];
  reg  [31:0] last = 32'h0;
  wire        sel  = ~&cs_n;
  int         j;
  // Known contents, so a read of an unwritten word never goes unknown
  initial begin
    for (j = 0; j < 16; j++)
      mem[j] = 32'h0;
  end
  // Released bus toggles so a late sample never looks valid
  assign dq_in = (sel && !(rd_n && nrd_n)) ? mem[addr[5:2]] : ~last;
  always @(posedge clk) begin
    last <= dq_in;
    if (sel && !oe_n && !(wr_n && nwr_n))
      mem[addr[5:2]] <= dq_out;
  end
endmodule // ebtad_mem_model

// File: sim/ebtad_top_properties.sv
// Port-level properties of the bus timing engine
`timescale 1ns/1ps
// ==========================================================
// Checker
module ebtad_top_checker #(
  parameter AW = 25,
  parameter DW = 32
) (
  // Clock and reset
  input wire          SYS_CLK,
  input wire          RESET,
  // Bus answer
  input wire          HREADYOUT,
  input wire          HRESP,
  input wire [31:0]   HRDATA,
  // Memory side
  input wire [AW-1:0] MEM_ADDR,
  input wire [7:0]    MEM_CHIP_SELECT_N,
  input wire          MEM_READ_STROBE_N,
  input wire          MEM_WRITE_STROBE_N,
  input wire [DW-1:0] MEM_DQ_IN,
  input wire          MEM_DQ_OE_N
);
  wire idle_cs = &MEM_CHIP_SELECT_N;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  AST_ONE_CS: assert property ($onehot0(~MEM_CHIP_SELECT_N))
    else $error("more than one chip select low");
  AST_ADDR_HELD: assert property (!idle_cs && !$past(idle_cs) |-> $stable(MEM_ADDR))
    else $error("address moved inside an access");
  AST_WR_SETUP: assert property ($fell(idle_cs) |-> MEM_WRITE_STROBE_N)
    else $error("write strobe in first setup cycle");
  AST_RD_IN_CS: assert property (!MEM_READ_STROBE_N |-> !idle_cs)
    else $error("read strobe without chip select");
  AST_STALL: assert property (!idle_cs |-> !HREADYOUT)
    else $error("bus released during access");
  AST_ERR: assert property ($rose(HRESP) |-> !HREADYOUT && idle_cs ##1 HRESP && HREADYOUT ##1 !HRESP)
    else $error("error response shape wrong");
  AST_OE_IN_CS: assert property (!MEM_DQ_OE_N |-> !idle_cs)
    else $error("data driven outside access");
  AST_IDLE: assert property ($rose(idle_cs) |-> !HREADYOUT ##1 idle_cs)
    else $error("no idle after access");
  AST_RD_DATA: assert property ($rose(idle_cs) && !$past(MEM_READ_STROBE_N) |-> HRDATA == $past(MEM_DQ_IN))
    else $error("read data not from last cycle");
  cover property ($fell(MEM_WRITE_STROBE_N));
  cover property ($fell(MEM_READ_STROBE_N));
  cover property ($rose(HRESP));
endmodule // ebtad_top_checker

bind ebtad_top ebtad_top_checker #(.AW(AW), .DW(DW)) u_chk (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA),
  .MEM_ADDR(MEM_ADDR), .MEM_CHIP_SELECT_N(MEM_CHIP_SELECT_N), .MEM_READ_STROBE_N(MEM_READ_STROBE_N),
  .MEM_WRITE_STROBE_N(MEM_WRITE_STROBE_N), .MEM_DQ_IN(MEM_DQ_IN), .MEM_DQ_OE_N(MEM_DQ_OE_N));

// File: sim/test_ext_bus_timing_area_decode.sv
// Register-level bench for the bus timing and area decode block
`timescale 1ns/1ps
// ==========================================================
// Bench top
module test_ext_bus_timing_area_decode;
  localparam [31:0] RT = 32'h1000_0000;
  localparam [31:0] RA = 32'h1000_0020;
  localparam [31:0] RM = 32'h1000_0040;
  reg         SYS_CLK = 1'b0;
  reg         RESET   = 1'b1;
  reg         HSEL    = 1'b0;
  reg  [31:0] HADDR   = 32'h0;
  reg  [1:0]  HTRANS  = 2'h0;
  reg         HWRITE  = 1'b0;
  reg  [31:0] HWDATA  = 32'h0;
  wire        HREADYOUT, HRESP, rd_n, wr_n, nrd_n, nwr_n, oe_n;
  wire [31:0] HRDATA, dq_in, dq_out;
  wire [24:0] mem_addr;
  wire [7:0]  cs_n;
  reg  [31:0] rdv, a;
  reg         er;
  reg  [7:0]  last_cs;
  reg  [24:0] last_addr;
  int         miscompares = 0, check_count = 0, i;
  int         cs_len, wr_pre, wr_len, rd_pre, rd_len, nrd_len, nwr_len, gap, cs_idle = 1;

  always #50 SYS_CLK = ~SYS_CLK;

  ebtad_top DUT (
    .SYS_CLK(SYS_CLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .HRDATA(HRDATA), .MEM_ADDR(mem_addr), .MEM_CHIP_SELECT_N(cs_n), .MEM_READ_STROBE_N(rd_n),
    .MEM_WRITE_STROBE_N(wr_n), .MEM_NAND_WRITE_STROBE_N(nwr_n), .MEM_NAND_READ_STROBE_N(nrd_n),
    .MEM_DQ_IN(dq_in), .MEM_DQ_OUT(dq_out), .MEM_DQ_OE_N(oe_n));
  ebtad_mem_model u_mem (
    .clk(SYS_CLK), .addr(mem_addr), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .nrd_n(nrd_n),
    .nwr_n(nwr_n), .dq_out(dq_out), .oe_n(oe_n), .dq_in(dq_in));

  // ==========================================================
  // Strobe timing monitor, cleared at each access start
  always @(posedge SYS_CLK) begin
    if (!(&cs_n)) begin
      if (cs_idle)
        {cs_len, wr_pre, wr_len, rd_pre, rd_len, nrd_len, nwr_len, gap} = 0;
      cs_len++;
      if (!wr_n) wr_len++;
      else if (wr_len == 0) wr_pre++;
      if (!rd_n) rd_len++;
      else if (rd_len == 0) rd_pre++;
      if (!nrd_n) nrd_len++;
      if (!nwr_n) nwr_len++;
      last_cs = cs_n;
      last_addr = mem_addr;
    end else if (!HREADYOUT) gap++;
    cs_idle = &cs_n;
  end

  // ==========================================================
  // Bus tasks
  task chk(input [31:0] seen, input [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge SYS_CLK);
    while (HREADYOUT !== 1'b1 && n < 1000) begin
      @(posedge SYS_CLK);
      n++;
    end
    if (n >= 1000) miscompares++;
  endtask
  task automatic xfer(input w, input [31:0] ad, input [31:0] d);
    @(posedge SYS_CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= ad;
    HWRITE <= w;
    wait_rdy();
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    wait_rdy();
    rdv = HRDATA;
    er = HRESP;
  endtask
  task automatic wr(input [31:0] ad, input [31:0] d);
    xfer(1'b1, ad, d);
  endtask
  task automatic rd(input [31:0] ad);
    xfer(1'b0, ad, 32'h0);
  endtask
  task print_verdict;
    $display("comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial begin
    repeat (20) @(posedge SYS_CLK);
    RESET <= 1'b0;
    rd(RT);
    chk(rdv, 32'h055ff00f);
    for (i = 0; i < 8; i++) begin
      rd(RA + 4 * i);
      chk(rdv, 32'h000f0000 | (i << 4));
    end
    wr(32'h1000_0070, 32'hffffffff);
    rd(32'h1000_0070);
    chk(rdv, 32'h0);
    // Default regions: one select per 16MB, 25 address bits out
    for (i = 0; i < 8; i++) begin
      a = (i << 24) | 32'h00a5_5a5c;
      wr(a, i);
      chk({24'h0, last_cs}, {24'h0, ~(8'h01 << i)});
      chk(last_addr, a[24:0]);
    end
    // 4MB region at the mask edge, then unmapped hits
    wr(RA + 8, 32'h0003_0028);
    rd(32'h02bf_fffc);
    chk(er, 1'b0);
    chk({24'h0, last_cs}, 32'hfb);
    rd(32'h02c0_0000);
    chk(er, 1'b1);
    rd(32'h0800_0000);
    chk(er, 1'b1);
    // Status is read-only: last select 2, a read, then an error
    wr(32'h1000_0060, 32'hffffffff);
    rd(32'h1000_0060);
    chk(rdv, 32'h0000_0022);
    // Write then read with short timing
    wr(RT, 32'h0215_3124);
    wr(32'h10, 32'h1234_5678);
    chk(cs_len, 6);
    chk(wr_pre, 2);
    chk(wr_len, 3);
    chk(gap, 1);
    rd(32'h10);
    chk(rdv, 32'h1234_5678);
    chk(cs_len, 5);
    chk(rd_pre, 2);
    chk(rd_len, 3);
    chk(gap, 4);
    wr(RM, 32'h2);
    rd(32'h10);
    chk(rd_pre, 2);
    chk(rd_len, 2);
    wr(RM, 32'h4);
    rd(32'h10);
    chk(rdv, 32'h1234_5678);
    chk(nrd_len, 3);
    chk(rd_len, 0);
    // NAND write uses the same windows on its own strobe
    wr(32'h14, 32'h5a5a_1234);
    chk(nwr_len, 3);
    chk(wr_len, 0);
    rd(32'h14);
    chk(rdv, 32'h5a5a_1234);
    // Page reads: first in a 16-byte page waits longer
    wr(RT + 4, 32'h0002_0302);
    wr(RM + 4, 32'h1);
    rd(32'h0100_0000);
    chk(cs_len, 6);
    chk(rd_pre, 0);
    rd(32'h0100_0004);
    chk(cs_len, 3);
    rd(32'h0100_0010);
    chk(cs_len, 6);
    print_verdict();
  end

  // Whole run is a few hundred cycles; this cuts a hang short
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    miscompares++;
    print_verdict();
  end
endmodule // test_ext_bus_timing_area_decode
